// File: rtl/cdc_pkg.sv
package cdc_pkg;
    // ****************************************************************
    // Geometry and field widths
    // ****************************************************************
    localparam int N_CH       = 8;
    localparam int N_OUT      = 16;
    localparam int FB_W       = 12;
    localparam int COARSE_W   = 9;
    localparam int FINE_W     = 2;
    localparam int ANLG_W     = 3;
    localparam int ADDR_W     = 8;
    // One source period spans this many half-period units
    localparam int HALF_PER_FULL = 2;
    // Fine line taps reach 3 full periods in half units
    localparam int FINE_DEPTH = 7;
    localparam int ANLG_DEPTH = 8;
    // Output to channel map: A, B0-1, C0-1, D0-1, E0-2, F0-1, G, H0-2
    localparam logic [2:0] OUT_CH [N_OUT] = '{3'h0, 3'h1, 3'h1, 3'h2, 3'h2, 3'h3, 3'h3,
        3'h4, 3'h4, 3'h4, 3'h5, 3'h5, 3'h6, 3'h7, 3'h7, 3'h7};
    localparam logic [2:0] CH_RF_C = 3'h2;
    localparam logic [2:0] CH_RF_D = 3'h3;
    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_PERIOD_PS = 4000;
    localparam int ANLG_STEP_PS  = 30;
    localparam int ANLG_STEP_CYC = (ANLG_STEP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // ****************************************************************
    // Register offsets (byte addresses)
    // ****************************************************************
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_FB     = 8'h04;
    localparam logic [7:0] ADDR_MODE   = 8'h08;
    localparam logic [7:0] ADDR_STAT   = 8'h0C;
    localparam logic [7:0] ADDR_COARSE = 8'h20;
    localparam logic [7:0] ADDR_OUT    = 8'h40;
    // CTRL fields
    localparam int CTRL_EXT_SRC = 0;
    localparam int CTRL_HALVE   = 1;
    localparam int CTRL_LT2G    = 2;
    localparam int CTRL_W       = 3;
    // MODE fields: [7:0] SYSREF select per channel, [9:8] bypass C, D
    localparam int MODE_BYP_C = 8;
    localparam int MODE_BYP_D = 9;
    localparam int MODE_W     = 10;
    // COARSE fields: [8:0] delay, [12] fine unit select
    localparam int CRS_UNIT = 12;
    localparam int CRS_W    = 13;
    // OUT fields
    localparam int OC_FINE     = 0;
    localparam int OC_ANLG     = 2;
    localparam int OC_FINE_OFF = 6;
    localparam int OC_EN       = 7;
    localparam int OC_PD       = 8;
    localparam int OC_BIAS     = 9;
    localparam int OC_PATH_OFF = 10;
    localparam int OC_STYLE    = 11;
    localparam int OC_INV      = 12;
    localparam int OC_W        = 13;
    // Reset values
    localparam logic [CTRL_W-1:0] CTRL_RST = 3'h0;
    localparam logic [MODE_W-1:0] MODE_RST = 10'h000;
    localparam logic [OC_W-1:0]   OUT_RST  = 13'h0000;
endpackage

// File: rtl/cdc_out_if.sv
`timescale 1ns/1ps
`default_nettype none
// Bundle between the top and one output stage
interface cdc_out_if;
    logic sig;
    logic sysref_mode;
    logic rf_bypass;
    logic pd;
    logic en;
    logic bias;
    logic path_off;
    logic style;
    logic inv;
    logic q;
    logic qn;
    logic pwr;
    modport stage (input sig, sysref_mode, rf_bypass, pd, en, bias, path_off, style, inv,
                   output q, qn, pwr);
    modport ctrl  (output sig, sysref_mode, rf_bypass, pd, en, bias, path_off, style, inv,
                   input q, qn, pwr);
endinterface
`default_nettype wire

// File: rtl/cdc_delay_line.sv
`timescale 1ns/1ps
`default_nettype none
module cdc_delay_line #(
    parameter int DEPTH = 8,
    parameter int TAP_W = 3
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Shift enable and tap request
    input  wire logic             en,
    input  wire logic [TAP_W-1:0] tap_req,
    // Data
    input  wire logic             din,
    output logic                  dout
);
    logic [DEPTH-1:0] sr_reg;
    logic [TAP_W-1:0] tap_reg;
    logic             quiet;

    // Shift the stream one step per enable
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            sr_reg <= '0;
        else if (en)
            sr_reg <= {sr_reg[DEPTH-2:0], din};
    end

    // Line holds no edge in flight, so a tap move cannot cut a pulse
    assign quiet = (sr_reg == {DEPTH{din}});

    // Adopt a new tap only while quiet
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            tap_reg <= '0;
        else if (quiet)
            tap_reg <= tap_req;
    end

    // Tap zero passes the input straight through
    always_comb
    begin
        if (tap_reg == '0)
            dout = din;
        else
            dout = sr_reg[tap_reg - TAP_W'(1)];
    end
endmodule // cdc_delay_line
`default_nettype wire

// File: rtl/cdc_out_stage.sv
`timescale 1ns/1ps
`default_nettype none
module cdc_out_stage (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Output control bundle
    cdc_out_if.stage  o
);
    // Decode output pin states each cycle
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            o.q   <= 1'b0;
            o.qn  <= 1'b0;
            o.pwr <= 1'b0;
        end
        else if (o.pd)
        begin
            o.q   <= 1'b0; // RQ11
            o.qn  <= 1'b0;
            o.pwr <= 1'b0;
        end
        else if (!o.en)
        begin
            o.pwr <= 1'b1;
            o.q   <= o.rf_bypass; // RQ13
            o.qn  <= 1'b1; // RQ11
        end
        else if (!o.sysref_mode || o.rf_bypass)
        begin
            o.pwr <= 1'b1;
            o.q   <= o.sig; // RQ12
            o.qn  <= ~o.sig; // RQ11
        end
        else if (o.path_off)
        begin
            o.pwr <= o.inv | o.style;
            o.q   <= o.inv | o.style;
            o.qn  <= o.inv | o.style;
        end
        else if (o.bias)
        begin
            o.pwr <= 1'b1;
            o.q   <= 1'b0;
            o.qn  <= 1'b1;
        end
        else
        begin
            o.pwr <= 1'b1;
            o.q   <= o.sig ^ o.inv;
            o.qn  <= ~(o.sig ^ o.inv);
        end
    end
endmodule // cdc_out_stage
`default_nettype wire

// File: rtl/cdc_top.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// (RQ1) Feedback sync delayed by a 12-bit count of full source periods.
// (RQ2) Each channel sync delayed by a 9-bit count of half source periods.
// (RQ3) SYSREF fine delay: 2 bits, one full source period per step by default.
// (RQ4) Slow external source lets software choose full or half period fine steps.
// (RQ5) SYSREF analog delay: 3 bits, fixed short step independent of source.
// (RQ6) External source: delay units follow the source selector output rate.
// (RQ7) Software must enable halving for external oscillators above 4GHz.
// (RQ8) Fine and analog delays apply only in SYSREF channels.
// (RQ9) Fine and analog setting changes never cut or shorten output pulses.
// (RQ10) Fine delay can be powered down, bypassing it.
// (RQ11) Clock mode: power-down off, disabled low/high, enabled switching.
// (RQ12) Clock mode ignores SYSREF bias, path-off, style and invert bits.
// (RQ13) Disabled bypassed RF outputs drive both lines high.
// (RQ14) Coarse delay is per channel; fine and analog are per output.
// (RQ15) Delays count source edges; a zero setting adds no delay.
module cdc_top
    import cdc_pkg::*;
(
    // Clock and reset
    input  wire logic                     ref_clk,
    input  wire logic                     rst_n,
    // Wishbone slave
    input  wire logic                     wb_cyc_i,
    input  wire logic                     wb_stb_i,
    input  wire logic                     wb_we_i,
    input  wire logic [cdc_pkg::ADDR_W-1:0] wb_adr_i,
    input  wire logic [3:0]               wb_sel_i,
    input  wire logic [31:0]              wb_dat_i,
    output logic      [31:0]              wb_dat_o,
    output logic                          wb_ack_o,
    // Sync request and signal inputs
    input  wire logic                     sync_req,
    input  wire logic                     ext_osc_input,
    input  wire logic [cdc_pkg::N_CH-1:0] ch_sig_in,
    // Delayed sync pulses to the dividers
    output logic                          fb_sync,
    output logic      [cdc_pkg::N_CH-1:0] ch_sync,
    // Output pins
    output logic      [cdc_pkg::N_OUT-1:0] q_out,
    output logic      [cdc_pkg::N_OUT-1:0] qn_out,
    output logic      [cdc_pkg::N_OUT-1:0] pwr_out
);
    import cdc_pkg::*;

    // ****************************************************************
    // Reset and pin synchronisers
    // ****************************************************************
    logic       rst_meta_reg;
    logic       rst_sync_reg;
    logic       rstn;
    logic [1:0] sync_ff_reg;
    logic [1:0] osc_ff_reg;
    logic       sync_last_reg;
    logic       sync_pulse;
    logic       osc_sig;

    // Release reset through two flops
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end
    assign rstn = rst_sync_reg;

    // Two-flop synchronisers for pin inputs
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sync_ff_reg   <= 2'h0;
            osc_ff_reg    <= 2'h0;
            sync_last_reg <= 1'b0;
        end
        else
        begin
            sync_ff_reg   <= {sync_ff_reg[0], sync_req};
            osc_ff_reg    <= {osc_ff_reg[0], ext_osc_input};
            sync_last_reg <= sync_ff_reg[1];
        end
    end
    assign sync_pulse = sync_ff_reg[1] & ~sync_last_reg;
    assign osc_sig    = osc_ff_reg[1];

    // ****************************************************************
    // Register file
    // ****************************************************************
    logic [CTRL_W-1:0] ctrl_reg;
    logic [FB_W-1:0]   fb_reg;
    logic [MODE_W-1:0] mode_reg;
    logic [CRS_W-1:0]  coarse_reg [N_CH];
    logic [OC_W-1:0]   out_reg [N_OUT];
    logic              fb_busy_reg;
    logic [N_CH-1:0]   ch_busy_reg;
    logic              req;
    logic              wr;
    logic [31:0]       rd_next;
    logic [31:0]       wmask;

    assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr  = req & wb_we_i;
    assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    // Merge write data into a register under byte enables
    function automatic logic [31:0] merge(input logic [31:0] old);
        merge = (old & ~wmask) | (wb_dat_i & wmask);
    endfunction

    // Acknowledge one cycle after the request, drop the next cycle
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else
        begin
            wb_ack_o <= req;
            wb_dat_o <= req ? rd_next : 32'h0000_0000;
        end
    end

    // Global control writes
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ctrl_reg <= CTRL_RST;
            fb_reg   <= '0;
            mode_reg <= MODE_RST;
        end
        else if (wr)
        begin
            if (wb_adr_i == ADDR_CTRL)
                ctrl_reg <= CTRL_W'(merge(32'(ctrl_reg)));
            else if (wb_adr_i == ADDR_FB)
                fb_reg <= FB_W'(merge(32'(fb_reg)));
            else if (wb_adr_i == ADDR_MODE)
                mode_reg <= MODE_W'(merge(32'(mode_reg)));
        end
    end

    // Per-channel and per-output configuration writes
    generate
        for (genvar c = 0; c < N_CH; c++)
        begin : g_crs_reg
            always_ff @(posedge ref_clk or negedge rstn)
            begin
                if (!rstn)
                    coarse_reg[c] <= '0;
                else if (wr && wb_adr_i == ADDR_COARSE + ADDR_W'(4 * c))
                    coarse_reg[c] <= CRS_W'(merge(32'(coarse_reg[c])));
            end
        end
        for (genvar k = 0; k < N_OUT; k++)
        begin : g_out_reg
            always_ff @(posedge ref_clk or negedge rstn)
            begin
                if (!rstn)
                    out_reg[k] <= OUT_RST;
                else if (wr && wb_adr_i == ADDR_OUT + ADDR_W'(4 * k))
                    out_reg[k] <= OC_W'(merge(32'(out_reg[k])));
            end
        end
    endgenerate

    // Read decode; unmapped addresses read zero
    always_comb
    begin
        rd_next = 32'h0000_0000;
        if (wb_adr_i == ADDR_CTRL)
            rd_next = 32'(ctrl_reg);
        else if (wb_adr_i == ADDR_FB)
            rd_next = 32'(fb_reg);
        else if (wb_adr_i == ADDR_MODE)
            rd_next = 32'(mode_reg);
        else if (wb_adr_i == ADDR_STAT)
            rd_next = {23'h000000, ch_busy_reg, fb_busy_reg};
        else if (wb_adr_i >= ADDR_COARSE && wb_adr_i < ADDR_COARSE + ADDR_W'(4 * N_CH)
                 && wb_adr_i[1:0] == 2'h0)
            rd_next = 32'(coarse_reg[3'(wb_adr_i[4:2])]);
        else if (wb_adr_i >= ADDR_OUT && wb_adr_i < ADDR_OUT + ADDR_W'(4 * N_OUT)
                 && wb_adr_i[1:0] == 2'h0)
            rd_next = 32'(out_reg[4'(wb_adr_i[5:2])]);
    end

    // ****************************************************************
    // Delay unit enables
    // ****************************************************************
    logic ext_halve;
    logic half_tgl_reg;
    logic full_tgl_reg;
    logic half_en;
    logic full_en;

    // External source halved only when selected and in use
    assign ext_halve = ctrl_reg[CTRL_EXT_SRC] & ctrl_reg[CTRL_HALVE]; // RQ6 RQ7

    // Half-period units each cycle, or each other cycle when halved
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            half_tgl_reg <= 1'b0;
            full_tgl_reg <= 1'b0;
        end
        else
        begin
            half_tgl_reg <= ext_halve ? ~half_tgl_reg : 1'b0;
            if (half_en)
                full_tgl_reg <= ~full_tgl_reg;
        end
    end
    assign half_en = ~ext_halve | half_tgl_reg; // RQ6
    assign full_en = half_en & full_tgl_reg;    // RQ15

    // ****************************************************************
    // Feedback and channel coarse delays
    // ****************************************************************
    logic [FB_W-1:0]     fb_cnt_reg;
    logic [COARSE_W-1:0] ch_cnt_reg [N_CH];

    // Feedback sync counted in full source periods
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            fb_cnt_reg  <= '0;
            fb_busy_reg <= 1'b0;
            fb_sync     <= 1'b0;
        end
        else
        begin
            fb_sync <= 1'b0;
            if (sync_pulse)
            begin
                fb_cnt_reg  <= fb_reg; // RQ1
                fb_busy_reg <= 1'b1;
            end
            else if (fb_busy_reg && fb_cnt_reg == '0)
            begin
                fb_sync     <= 1'b1; // RQ15
                fb_busy_reg <= 1'b0;
            end
            else if (fb_busy_reg && full_en)
                fb_cnt_reg <= fb_cnt_reg - FB_W'(1); // RQ1
        end
    end

    // Channel sync counted in half source periods, shared by the channel
    generate
        for (genvar c = 0; c < N_CH; c++)
        begin : g_coarse
            always_ff @(posedge ref_clk or negedge rstn)
            begin
                if (!rstn)
                begin
                    ch_cnt_reg[c]  <= '0;
                    ch_busy_reg[c] <= 1'b0;
                    ch_sync[c]     <= 1'b0;
                end
                else
                begin
                    ch_sync[c] <= 1'b0;
                    if (sync_pulse)
                    begin
                        ch_cnt_reg[c]  <= coarse_reg[c][COARSE_W-1:0]; // RQ2 RQ14
                        ch_busy_reg[c] <= 1'b1;
                    end
                    else if (ch_busy_reg[c] && ch_cnt_reg[c] == '0)
                    begin
                        ch_sync[c]     <= 1'b1; // RQ15
                        ch_busy_reg[c] <= 1'b0;
                    end
                    else if (ch_busy_reg[c] && half_en)
                        ch_cnt_reg[c] <= ch_cnt_reg[c] - COARSE_W'(1); // RQ2
                end
            end
        end
    endgenerate

    // ****************************************************************
    // Per-output delays and output stages
    // ****************************************************************
    generate
        for (genvar k = 0; k < N_OUT; k++)
        begin : g_out
            localparam logic [2:0] CH = OUT_CH[k];
            localparam bit IS_RF = (CH == CH_RF_C) || (CH == CH_RF_D);
            logic        srm;
            logic        byp;
            logic        half_step;
            logic        fine_off;
            logic [2:0]  fine_tap;
            logic [2:0]  anlg_tap;
            logic        fine_out;
            logic        anlg_out;
            cdc_out_if   oif ();

            // Bypass of the RF outputs to the external oscillator
            if (IS_RF)
                assign byp = mode_reg[(CH == CH_RF_C) ? MODE_BYP_C : MODE_BYP_D];
            else
                assign byp = 1'b0;
            assign srm       = mode_reg[CH] & ~byp;
            // Half steps only for a slow external source on request
            assign half_step = ctrl_reg[CTRL_EXT_SRC] & ctrl_reg[CTRL_LT2G]
                               & coarse_reg[CH][CRS_UNIT]; // RQ4
            assign fine_off  = out_reg[k][OC_FINE_OFF] | ~srm; // RQ8 RQ10
            // Fine tap in half units: full step is two halves
            assign fine_tap  = fine_off ? 3'h0 :
                               half_step ? 3'(out_reg[k][OC_FINE +: FINE_W]) :
                               3'(out_reg[k][OC_FINE +: FINE_W] * HALF_PER_FULL); // RQ3
            assign anlg_tap  = srm ? 3'(out_reg[k][OC_ANLG +: ANLG_W] * ANLG_STEP_CYC)
                                   : 3'h0; // RQ5 RQ8

            // Fine delay, stepped by the source unit enable
            cdc_delay_line #(.DEPTH(FINE_DEPTH), .TAP_W(3)) u_fine (
                .clk     (ref_clk),
                .rst_n   (rstn),
                .en      (half_en | fine_off),  // RQ10
                .tap_req (fine_tap),
                .din     (ch_sig_in[CH]),
                .dout    (fine_out)              // RQ9
            );

            // Analog delay, independent of the source rate
            cdc_delay_line #(.DEPTH(ANLG_DEPTH), .TAP_W(3)) u_anlg (
                .clk     (ref_clk),
                .rst_n   (rstn),
                .en      (1'b1),                 // RQ5
                .tap_req (anlg_tap),
                .din     (fine_out),
                .dout    (anlg_out)              // RQ9
            );

            assign oif.sig         = byp ? osc_sig : anlg_out; // RQ14
            assign oif.sysref_mode = srm;
            assign oif.rf_bypass   = byp;     // RQ13
            assign oif.pd          = out_reg[k][OC_PD];
            assign oif.en          = out_reg[k][OC_EN];
            assign oif.bias        = out_reg[k][OC_BIAS];
            assign oif.path_off    = out_reg[k][OC_PATH_OFF];
            assign oif.style       = out_reg[k][OC_STYLE];
            assign oif.inv         = out_reg[k][OC_INV];

            // Pin state decode, registered
            cdc_out_stage u_stage (
                .clk   (ref_clk),
                .rst_n (rstn),
                .o     (oif.stage)
            );
            assign q_out[k]   = oif.q;
            assign qn_out[k]  = oif.qn;
            assign pwr_out[k] = oif.pwr;
        end
    endgenerate
endmodule // cdc_top
`default_nettype wire

// File: dv/cdc_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Port checks on the delay and output block
// ****
module cdc_checker (
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        rst_n,
    // Register bus
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    // Sync pulses and pins
    input wire logic        fb_sync,
    input wire logic [7:0]  ch_sync,
    input wire logic [15:0] q_out,
    input wire logic [15:0] qn_out,
    input wire logic [15:0] pwr_out
);
    // Bus answers, one-cycle sync pulses and quiet pins
    chk_ack_single: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
    chk_ack_cause: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
    chk_ack_answer: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o) else $error("ack late");
    chk_dat_idle: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data outside ack");
    chk_fb_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n)
        fb_sync |=> !fb_sync) else $error("feedback pulse too long");
    chk_ch_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (|ch_sync) |=> (ch_sync & $past(ch_sync)) == 8'h00) else $error("channel pulse too long");
    chk_pwr_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (~pwr_out & (q_out | qn_out)) == 16'h0000) else $error("powered down pin driven");
    chk_reset_quiet: assert property (@(posedge ref_clk)
        !rst_n |-> ((q_out | qn_out | pwr_out) == 16'h0000) && !wb_ack_o)
        else $error("pins active in reset");
endmodule // cdc_checker
bind cdc_top cdc_checker i_chk (.ref_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
    .wb_dat_o, .fb_sync, .ch_sync, .q_out, .qn_out, .pwr_out);
`default_nettype wire

// File: dv/cdc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module cdc_top_tb;
    import cdc_pkg::*;
    // Address table and the field bits each place keeps
    localparam logic [7:0]  ADRS [7] = '{ADDR_CTRL, ADDR_FB, ADDR_MODE, ADDR_STAT,
        8'h2C, 8'h7C, 8'h80};
    localparam logic [31:0] MSK [7] = '{32'h7, 32'hFFF, 32'h3FF, 32'h0, 32'h1FFF,
        32'h1FFF, 32'h0};
    logic        ref_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic        sync_req, ext_osc_input, fb_sync;
    logic [7:0]  wb_adr_i, ch_sig_in, ch_sync;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic [15:0] q_out, qn_out, pwr_out;
    int          fail_count, samples_checked, cycles;
    cdc_top i_dut (.ref_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .sync_req, .ext_osc_input, .ch_sig_in, .fb_sync,
        .ch_sync, .q_out, .qn_out, .pwr_out);
    // Clock
    initial
    begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    // Hang guard
    always @(posedge ref_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            fail_count++;
            end_of_test();
        end
    end
    // ****
    // Tasks
    // ****
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One classic cycle; read data lands in rd
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'hF;
        do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
        @(posedge ref_clk);
    endtask
    // Pin state of output k as {true, complement, powered}
    task automatic outchk(input int k, input logic [31:0] exp);
        repeat (4) @(posedge ref_clk);
        check({29'h0, q_out[k], qn_out[k], pwr_out[k]}, exp);
    endtask
    // Cycles from sync request to pulse idx (8 is feedback)
    task automatic sync_run(input int idx, input int exp, input int tol);
        int n;
        logic [8:0] s;
        n = 0;
        sync_req <= 1'b1;
        do
        begin
            @(posedge ref_clk);
            n++;
            s = {fb_sync, ch_sync};
        end while (s[idx] !== 1'b1 && n < 3000);
        sync_req <= 1'b0;
        check(32'((n >= exp - tol) && (n <= exp + tol)), 32'h1);
        repeat (8) @(posedge ref_clk);
    endtask
    // Configure output 0, flip the channel signals, count cycles to the pin
    task automatic dly_run(input logic [31:0] cfg, input int exp);
        int   n;
        logic lv;
        wb(1'b1, ADDR_OUT, cfg);
        repeat (10) @(posedge ref_clk);
        n = 0;
        lv = ~ch_sig_in[0];
        ch_sig_in <= {8{lv}};
        do
        begin
            @(posedge ref_clk);
            n++;
        end while (q_out[0] !== lv && n < 50);
        check(32'(n), 32'(exp));
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // ****
    // Main sequence
    // ****
    initial
    begin
        rst_n = 1'b0;
        {wb_cyc_i, wb_stb_i, wb_we_i, sync_req, ext_osc_input} = 5'h00;
        {wb_adr_i, ch_sig_in, wb_sel_i, wb_dat_i} = 52'h0;
        {fail_count, samples_checked, cycles} = '0;
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        for (int i = 0; i < 7; i++)
        begin
            wb(1'b0, ADRS[i], 32'h0);
            check(rd, 32'h0);
            wb(1'b1, ADRS[i], 32'hFFFF_FFFF);
            wb(1'b0, ADRS[i], 32'h0);
            check(rd, MSK[i]);
            wb(1'b1, ADRS[i], 32'h0);
        end
        for (int k = 0; k < 16; k++)
        begin
            ch_sig_in <= k[0] ? 8'h00 : 8'hFF;
            wb(1'b1, ADDR_OUT + 8'(k * 4), 32'h1E80);
            outchk(k, k[0] ? 32'h3 : 32'h5);
            wb(1'b1, ADDR_OUT + 8'(k * 4), 32'h1E00);
            outchk(k, 32'h3);
            wb(1'b1, ADDR_OUT + 8'(k * 4), 32'h100);
            outchk(k, 32'h0);
            wb(1'b1, ADDR_OUT + 8'(k * 4), 32'h0);
        end
        wb(1'b1, ADDR_MODE, 32'h100);
        outchk(3, 32'h7);
        ext_osc_input <= 1'b1;
        wb(1'b1, ADDR_OUT + 8'h0C, 32'h80);
        outchk(3, 32'h5);
        wb(1'b1, ADDR_MODE, 32'h1);
        wb(1'b1, ADDR_OUT, 32'h280);
        outchk(0, 32'h3);
        wb(1'b1, ADDR_OUT, 32'h1480);
        outchk(0, 32'h7);
        wb(1'b1, ADDR_MODE, 32'h0);
        sync_run(8, 6, 2);
        wb(1'b1, ADDR_FB, 32'h64);
        sync_run(8, 206, 4);
        wb(1'b1, ADDR_COARSE + 8'h1C, 32'h1FF);
        sync_run(7, 517, 3);
        wb(1'b1, ADDR_CTRL, 32'h3);
        wb(1'b1, ADDR_COARSE + 8'h1C, 32'h32);
        sync_run(7, 106, 5);
        wb(1'b1, ADDR_CTRL, 32'h0);
        wb(1'b1, ADDR_MODE, 32'h1);
        dly_run(32'h80, 2);
        dly_run(32'h81, 2 + HALF_PER_FULL);
        dly_run(32'h85, 2 + HALF_PER_FULL + ANLG_STEP_CYC);
        dly_run(32'hC1, 2);
        wb(1'b1, ADDR_CTRL, 32'h5);
        wb(1'b1, ADDR_COARSE, 32'h1000);
        dly_run(32'h81, 3);
        wb(1'b1, ADDR_MODE, 32'h0);
        dly_run(32'h85, 2);
        end_of_test();
    end
endmodule // cdc_top_tb
`default_nettype wire
